// >>> design/autoneg_advert_register.sv
// Auto-negotiation advertisement register with staged update and control bits
`timescale 1ns/100ps
`default_nettype none

module autoneg_advert_register
   import autoneg_advert_pkg::*;
(
   input  wire logic        sys_clk,            // 40 MHz system clock
   input  wire logic        srst,               // Hardware reset, active high
   input  wire logic [4:0]  regAddr,            // Register index
   input  wire logic [15:0] regWrData,          // Write data
   input  wire logic        regWr,              // Write strobe
   input  wire logic        regRd,              // Read strobe
   input  wire logic        strap_asym_pause_default, // Asym pause strap
   input  wire logic        strap_sym_pause_default,  // Pause strap
   input  wire logic        copperLinkUp,       // Copper link status
   output logic [15:0]      regRdData,          // Read data, cycle after read
   output logic [15:0]      advertWord,         // Code word to negotiation
   output logic             anEnableEff,        // Negotiation runs
   output logic             advGigFull,         // Gigabit full duplex offered
   output logic             advGigHalf,         // Gigabit half duplex offered
   output logic             autoNextPages,      // Send required next pages
   output logic             anRestart,          // One-cycle restart pulse
   output logic             softResetOut        // One-cycle soft reset pulse
);

   localparam int NSTAGED = 8;

   // Local control register and its event trackers
   logic [6:0]  control;
   logic        powerDownQ;
   logic        linkUpQ;
   logic        swResetQ;

   // Reset tracker and fields that bypass staging
   logic        hwInitDone;
   logic        pt4;
   logic [4:0]  selector;

   // Decode of accesses
   wire         wrAdvert  = regWr && (regAddr == ADDR_ADVERT);
   wire         wrControl = regWr && (regAddr == ADDR_AN_CONTROL);

   // Control events written by software
   wire         softResetReq = wrControl && regWrData[CTL_SOFT_RESET];
   wire         restartReq   = wrControl && regWrData[CTL_RESTART_AN];
   wire         nextPowerDown = wrControl ? regWrData[CTL_POWER_DOWN]
                                          : control[CTL_POWER_DOWN];

   // Update events: exit from power down and copper link loss are edges
   wire         wakeEvent = powerDownQ && !control[CTL_POWER_DOWN];
   wire         linkLoss  = linkUpQ && !copperLinkUp;
   wire         applyEvent = swResetQ || restartReq || wakeEvent
                             || linkLoss;

   // Staged bits in order 15,13,12,11,10,8,7; plus one spare slot unused
   wire [NSTAGED-1:0] stagedWr;
   wire [NSTAGED-1:0] stagedData;
   wire [NSTAGED-1:0] stagedReset;
   wire [NSTAGED-1:0] stagedLoad;
   wire [NSTAGED-1:0] stagedPend;
   wire [NSTAGED-1:0] stagedLive;

   // Slot of each staged bit in the vectors above
   localparam int IDX_NP = 0;
   localparam int IDX_RF = 1;
   localparam int IDX_RS = 2;
   localparam int IDX_AP = 3;
   localparam int IDX_PA = 4;
   localparam int IDX_FD = 5;
   localparam int IDX_HD = 6;
   localparam int IDX_SP = 7;

   // Field slices for the staged bits
   assign stagedData = {1'b0,
                        regWrData[BIT_TX_HD],
                        regWrData[BIT_TX_FD],
                        regWrData[BIT_PAUSE],
                        regWrData[BIT_ASYM_PAUSE],
                        regWrData[BIT_RESERVED],
                        regWrData[BIT_REMOTE_FAULT],
                        regWrData[BIT_NEXT_PAGE]};

   // Seven cells take writes; the spare slot never does
   assign stagedWr   = {1'b0, {(NSTAGED-1){wrAdvert}}};

   // Straps are caught one cycle after hardware reset release
   assign stagedLoad  = {NSTAGED{!hwInitDone}};
   assign stagedReset = {1'b0,
                         ADVERT_HW_RESET[BIT_TX_HD],
                         ADVERT_HW_RESET[BIT_TX_FD],
                         strap_sym_pause_default,
                         strap_asym_pause_default,
                         ADVERT_HW_RESET[BIT_RESERVED],
                         ADVERT_HW_RESET[BIT_REMOTE_FAULT],
                         ADVERT_HW_RESET[BIT_NEXT_PAGE]};

   // One staged cell per update-on-event bit
   staged_bit #(.RESET_VALUE(1'b0)) u_np (
      .sys_clk    (sys_clk),
      .srst       (srst),
      .loadReset  (stagedLoad[IDX_NP]),
      .resetValue (stagedReset[IDX_NP]),
      .wrEn       (stagedWr[IDX_NP]),
      .wrData     (stagedData[IDX_NP]),
      .applyEvent (applyEvent),
      .pending    (stagedPend[IDX_NP]),
      .active     (stagedLive[IDX_NP])
   );

   staged_bit #(.RESET_VALUE(1'b0)) u_rf (
      .sys_clk    (sys_clk),
      .srst       (srst),
      .loadReset  (stagedLoad[IDX_RF]),
      .resetValue (stagedReset[IDX_RF]),
      .wrEn       (stagedWr[IDX_RF]),
      .wrData     (stagedData[IDX_RF]),
      .applyEvent (applyEvent),
      .pending    (stagedPend[IDX_RF]),
      .active     (stagedLive[IDX_RF])
   );

   staged_bit #(.RESET_VALUE(1'b0)) u_rs (
      .sys_clk    (sys_clk),
      .srst       (srst),
      .loadReset  (stagedLoad[IDX_RS]),
      .resetValue (stagedReset[IDX_RS]),
      .wrEn       (stagedWr[IDX_RS]),
      .wrData     (stagedData[IDX_RS]),
      .applyEvent (applyEvent),
      .pending    (stagedPend[IDX_RS]),
      .active     (stagedLive[IDX_RS])
   );

   staged_bit #(.RESET_VALUE(1'b0)) u_ap (
      .sys_clk    (sys_clk),
      .srst       (srst),
      .loadReset  (stagedLoad[IDX_AP]),
      .resetValue (stagedReset[IDX_AP]),
      .wrEn       (stagedWr[IDX_AP]),
      .wrData     (stagedData[IDX_AP]),
      .applyEvent (applyEvent),
      .pending    (stagedPend[IDX_AP]),
      .active     (stagedLive[IDX_AP])
   );

   staged_bit #(.RESET_VALUE(1'b0)) u_pa (
      .sys_clk    (sys_clk),
      .srst       (srst),
      .loadReset  (stagedLoad[IDX_PA]),
      .resetValue (stagedReset[IDX_PA]),
      .wrEn       (stagedWr[IDX_PA]),
      .wrData     (stagedData[IDX_PA]),
      .applyEvent (applyEvent),
      .pending    (stagedPend[IDX_PA]),
      .active     (stagedLive[IDX_PA])
   );

   staged_bit #(.RESET_VALUE(1'b1)) u_fd (
      .sys_clk    (sys_clk),
      .srst       (srst),
      .loadReset  (stagedLoad[IDX_FD]),
      .resetValue (stagedReset[IDX_FD]),
      .wrEn       (stagedWr[IDX_FD]),
      .wrData     (stagedData[IDX_FD]),
      .applyEvent (applyEvent),
      .pending    (stagedPend[IDX_FD]),
      .active     (stagedLive[IDX_FD])
   );

   staged_bit #(.RESET_VALUE(1'b1)) u_hd (
      .sys_clk    (sys_clk),
      .srst       (srst),
      .loadReset  (stagedLoad[IDX_HD]),
      .resetValue (stagedReset[IDX_HD]),
      .wrEn       (stagedWr[IDX_HD]),
      .wrData     (stagedData[IDX_HD]),
      .applyEvent (applyEvent),
      .pending    (stagedPend[IDX_HD]),
      .active     (stagedLive[IDX_HD])
   );

   // Spare slot tied off so the vectors stay a round width
   assign stagedPend[IDX_SP] = 1'b0;
   assign stagedLive[IDX_SP] = 1'b0;

   // Hardware-reset tracker: the straps are sampled once after release
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         hwInitDone <= 1'b0;
      end else begin
         hwInitDone <= 1'b1;
      end
   end

   // T4 bit writes take effect at once and survive software reset
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pt4 <= ADVERT_HW_RESET[BIT_T4];
      end else if (wrAdvert) begin
         pt4 <= regWrData[BIT_T4];
      end
   end

   // Selector is not staged either and keeps its value over soft reset
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         selector <= SELECTOR_RESET;
      end else if (wrAdvert) begin
         selector <= regWrData[SEL_MSB:0];
      end
   end

   // Control register; reset and restart bits self-clear
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         control <= CONTROL_RESET;
      end else begin
         if (wrControl) begin
            control <= regWrData[6:0];
         end
         control[CTL_SOFT_RESET] <= 1'b0;
         control[CTL_RESTART_AN] <= 1'b0;
         control[CTL_POWER_DOWN] <= nextPowerDown;
      end
   end

   // Delayed copies for edge events; link copy starts low, no false loss
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         powerDownQ <= 1'b0;
         linkUpQ    <= 1'b0;
         swResetQ   <= 1'b0;
      end else begin
         powerDownQ <= control[CTL_POWER_DOWN];
         linkUpQ    <= copperLinkUp;
         swResetQ   <= softResetReq;
      end
   end

   // Forced gigabit keeps negotiation alive with one duplex only
   wire forced1000 = !control[CTL_AN_ENABLE] && control[CTL_FORCE_1000];
   wire next_gigFull = forced1000 ? control[CTL_FULL_DUPLEX]
                                  : control[CTL_ADV_1000];
   wire next_gigHalf = forced1000 && !control[CTL_FULL_DUPLEX];

   // Code word sent: 10/100 bits dropped in forced gigabit mode
   wire [15:0] next_advert = {stagedLive[IDX_NP],
                              1'b0,
                              stagedLive[IDX_RF],
                              stagedLive[IDX_RS],
                              stagedLive[IDX_AP],
                              stagedLive[IDX_PA],
                              pt4 && !forced1000,
                              stagedLive[IDX_FD] && !forced1000,
                              stagedLive[IDX_HD] && !forced1000,
                              2'b00,
                              selector};

   // Software view shows pending values
   wire [15:0] advertView = {stagedPend[IDX_NP],
                             1'b0,
                             stagedPend[IDX_RF],
                             stagedPend[IDX_RS],
                             stagedPend[IDX_AP],
                             stagedPend[IDX_PA],
                             pt4,
                             stagedPend[IDX_FD],
                             stagedPend[IDX_HD],
                             2'b00,
                             selector};

   // Status view: link, forced gigabit, power down, negotiation on
   wire [15:0] statusView = {12'h000, copperLinkUp, forced1000,
                             control[CTL_POWER_DOWN], anEnableEff};

   // Read mux; unmapped indices read as zero
   wire [15:0] next_rdData =
      (regAddr == ADDR_ADVERT)     ? advertView :
      (regAddr == ADDR_AN_CONTROL) ? {9'h000, control} :
      (regAddr == ADDR_AN_STATUS)  ? statusView : 16'h0000;

   // Read data stands one cycle after the strobe, zero otherwise
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         regRdData <= 16'h0000;
      end else begin
         regRdData <= regRd ? next_rdData : 16'h0000;
      end
   end

   // Live code word toward negotiation
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         advertWord <= ADVERT_HW_RESET;
      end else begin
         advertWord <= next_advert;
      end
   end

   // Negotiation levels; next pages follow gigabit, not bit 15
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         anEnableEff   <= 1'b1;
         advGigFull    <= 1'b1;
         advGigHalf    <= 1'b0;
         autoNextPages <= 1'b1;
      end else begin
         anEnableEff   <= control[CTL_AN_ENABLE] || forced1000;
         advGigFull    <= next_gigFull;
         advGigHalf    <= next_gigHalf;
         autoNextPages <= next_gigFull || next_gigHalf;
      end
   end

   // One-cycle pulses toward the negotiation engine
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         anRestart    <= 1'b0;
         softResetOut <= 1'b0;
      end else begin
         anRestart    <= applyEvent;
         softResetOut <= swResetQ;
      end
   end

endmodule : autoneg_advert_register
`default_nettype wire

// >>> design/autoneg_advert_pkg.sv
// Package of offsets, field positions and reset values for the advert register
package autoneg_advert_pkg;

   localparam int          REG_ADDR_W        = 5;
   // Register offsets (register index on the management port)
   localparam logic [4:0]  ADDR_ADVERT       = 5'h04;
   localparam logic [4:0]  ADDR_AN_CONTROL   = 5'h10;
   localparam logic [4:0]  ADDR_AN_STATUS    = 5'h11;

   // Field positions of the advertisement register
   localparam int          BIT_NEXT_PAGE     = 15;
   localparam int          BIT_ACK           = 14;
   localparam int          BIT_REMOTE_FAULT  = 13;
   localparam int          BIT_RESERVED      = 12;
   localparam int          BIT_ASYM_PAUSE    = 11;
   localparam int          BIT_PAUSE         = 10;
   localparam int          BIT_T4            = 9;
   localparam int          BIT_TX_FD         = 8;
   localparam int          BIT_TX_HD         = 7;
   localparam int          SEL_MSB           = 4;

   // Field positions of the local control register
   localparam int          CTL_SOFT_RESET    = 0;
   localparam int          CTL_RESTART_AN    = 1;
   localparam int          CTL_POWER_DOWN    = 2;
   localparam int          CTL_AN_ENABLE     = 3;
   localparam int          CTL_FORCE_1000    = 4;
   localparam int          CTL_FULL_DUPLEX   = 5;
   localparam int          CTL_ADV_1000      = 6;

   // Reset values
   localparam logic [15:0] ADVERT_HW_RESET   = 16'h0181;
   localparam logic [4:0]  SELECTOR_RESET    = 5'h01;
   localparam logic [6:0]  CONTROL_RESET     = 7'h48;

endpackage : autoneg_advert_pkg

// >>> design/staged_bit.sv
// One staged advertisement bit: written value pending until an update event
`timescale 1ns/100ps
`default_nettype none

module staged_bit #(
   parameter logic RESET_VALUE = 1'b0           // Value after reset
) (
   input  wire logic sys_clk,                   // System clock
   input  wire logic srst,                      // Synchronous reset
   input  wire logic loadReset,                 // Take resetValue now
   input  wire logic resetValue,                // Value taken on loadReset
   input  wire logic wrEn,                      // Software write of this bit
   input  wire logic wrData,                    // Written value
   input  wire logic applyEvent,                // Update event: pending goes live
   output logic      pending,                   // Software view of the bit
   output logic      active                     // Value used by negotiation
);

   // Pending follows writes; active copies pending only on an event
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pending <= RESET_VALUE;
         active  <= RESET_VALUE;
      end else if (loadReset) begin
         pending <= resetValue;
         active  <= resetValue;
      end else begin
         if (wrEn) begin
            pending <= wrData;
         end
         // A write in the event cycle goes live at once
         if (applyEvent) begin
            active <= wrEn ? wrData : pending;
         end
      end
   end

endmodule : staged_bit
`default_nettype wire

// >>> test/autoneg_advert_props.sv
// Concurrent checks on the advertisement register ports
`timescale 1ns/100ps
`default_nettype none

module autoneg_advert_props
   import autoneg_advert_pkg::*;
(
   input  wire logic        sys_clk,       // System clock
   input  wire logic        srst,          // Hardware reset
   input  wire logic [4:0]  regAddr,       // Register index
   input  wire logic [15:0] regWrData,     // Write data
   input  wire logic        regWr,         // Write strobe
   input  wire logic        regRd,         // Read strobe
   input  wire logic        copperLinkUp,  // Link status
   input  wire logic [15:0] regRdData,     // Read data
   input  wire logic [15:0] advertWord,    // Live code word
   input  wire logic        advGigFull,    // Gigabit full offered
   input  wire logic        advGigHalf,    // Gigabit half offered
   input  wire logic        autoNextPages, // Send next pages
   input  wire logic        anRestart,     // Restart pulse
   input  wire logic        softResetOut   // Soft reset pulse
);
   logic [2:0] relCnt;
   logic       settled;
   logic       ctlWr;

   // Strap load moves the word just after reset, so hold checks off a while
   always_ff @(posedge sys_clk) begin
      if (srst) relCnt <= 3'h0;
      else if (relCnt != 3'h7) relCnt <= relCnt + 3'h1;
   end
   assign settled = (relCnt > 3'h4);
   assign ctlWr   = regWr && (regAddr == ADDR_AN_CONTROL);

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   a_read_idle_zero: assert property (
      !$past(regRd) |-> regRdData == 16'h0) else $error("Read data off slot");
   a_ack_zero: assert property (
      !regRdData[BIT_ACK] && !advertWord[BIT_ACK]) else $error("Ack bit set");
   a_staged_hold: assert property (
      settled && $changed(advertWord[15:10]) |->
      anRestart || $past(anRestart) || $past(anRestart, 2))
      else $error("Live word moved without event");
   a_restart_event: assert property (
      ctlWr && regWrData[CTL_RESTART_AN] |-> ##[1:2] anRestart)
      else $error("No restart after restart write");
   a_soft_reset_pulse: assert property (
      ctlWr && regWrData[CTL_SOFT_RESET] |-> ##2 softResetOut)
      else $error("No soft reset pulse");
   a_soft_single: assert property (
      softResetOut |=> !softResetOut) else $error("Soft reset pulse too long");
   a_link_loss_event: assert property (
      settled && $fell(copperLinkUp) |-> ##[1:3] anRestart)
      else $error("No restart after link loss");
   a_gig_next_pages: assert property (
      settled |-> autoNextPages == (advGigFull || advGigHalf))
      else $error("Next pages disagree with gigabit offer");

   c_restart: cover property (anRestart);
   c_soft: cover property (softResetOut);
   c_link_loss: cover property ($fell(copperLinkUp));

endmodule : autoneg_advert_props

`default_nettype wire

// >>> test/link_partner_model.sv
// Link partner: drops the copper link on request, samples the base page
`timescale 1ns/100ps
`default_nettype none

module link_partner_model (
   input  wire logic        sys_clk,      // System clock
   input  wire logic        dropReq,      // Request a link drop
   input  wire logic [3:0]  dropLag,      // Cycles before the drop
   input  wire logic        anRestart,    // Negotiation restart
   input  wire logic [15:0] advertWord,   // Code word offered
   output logic             copperLinkUp, // Link status
   output logic [15:0]      codeWord,     // Base page received
   output logic             codeValid     // Base page strobe
);
   initial begin
      copperLinkUp = 1'b1;
      codeWord     = 16'h0;
      codeValid    = 1'b0;
   end

   // Lag may be zero or long; link stays down long enough to be seen
   always @(posedge sys_clk) begin
      if (dropReq) begin
         repeat (dropLag) @(posedge sys_clk);
         copperLinkUp <= 1'b0;
         repeat (6) @(posedge sys_clk);
         copperLinkUp <= 1'b1;
      end
   end

   // Base page is taken once the restarted word has settled
   always @(posedge sys_clk) begin
      codeValid <= 1'b0;
      if (anRestart) begin
         repeat (3) @(posedge sys_clk);
         codeWord  <= advertWord;
         codeValid <= 1'b1;
      end
   end

endmodule : link_partner_model

`default_nettype wire

// >>> test/autoneg_advert_register_test.sv
// Self-checking bench for the advertisement register
`timescale 1ns/100ps
`default_nettype none

module autoneg_advert_register_test import autoneg_advert_pkg::*;;
   logic        sys_clk, srst, regWr, regRd, strapAsym, strapSym;
   logic        copperLinkUp, anEnableEff, advGigFull, advGigHalf;
   logic        autoNextPages, anRestart, softResetOut, codeValid;
   logic        dropReq, rdPend;
   logic [3:0]  dropLag;
   logic [4:0]  regAddr;
   logic [15:0] regWrData, regRdData, advertWord, codeWord, live, d;
   logic [15:0] rq[$];
   logic [15:0] wq[$];
   int          mismatches, n_tests;

   autoneg_advert_register autoneg_advert_register_i (
      .sys_clk, .srst, .regAddr, .regWrData, .regWr, .regRd,
      .strap_asym_pause_default(strapAsym), .strap_sym_pause_default(strapSym),
      .copperLinkUp, .regRdData, .advertWord, .anEnableEff, .advGigFull,
      .advGigHalf, .autoNextPages, .anRestart, .softResetOut);
   link_partner_model link_partner_model_i (
      .sys_clk, .dropReq, .dropLag, .anRestart, .advertWord, .copperLinkUp,
      .codeWord, .codeValid);

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic test_done;
      $display("Checks %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : test_done

   task automatic wr(input logic [4:0] a, input logic [15:0] v);
      @(posedge sys_clk);
      regAddr   <= a;
      regWrData <= v;
      regWr     <= 1'b1;
      @(posedge sys_clk);
      regWr     <= 1'b0;
   endtask : wr

   task automatic rd(input logic [4:0] a, input logic [15:0] e);
      @(posedge sys_clk);
      regAddr <= a;
      regRd   <= 1'b1;
      rq.push_back(e);
      @(posedge sys_clk);
      regRd   <= 1'b0;
   endtask : rd

   // Fresh straps each time so both levels reach the reset word
   task automatic hw_reset;
      @(posedge sys_clk);
      strapAsym <= 1'($urandom);
      strapSym  <= 1'($urandom);
      srst      <= 1'b1;
      repeat (5) @(posedge sys_clk);
      srst      <= 1'b0;
      repeat (4) @(posedge sys_clk);
      live = {4'h0, strapAsym, strapSym, 10'h181};
   endtask : hw_reset

   // Write is held pending, then one of the four events makes it live
   task automatic stage_and_apply(input int ev);
      d = 16'($urandom);
      d[15] = 1'b0;
      d[6:0] = 7'h01;
      wr(ADDR_ADVERT, d);
      rd(ADDR_ADVERT, d & 16'hbfff);
      // T4 is not staged, so it is live already
      check(advertWord, {live[15:10], d[9], live[8:0]});
      live = d & 16'hbfff;
      wq.push_back(live);
      case (ev)
         0: wr(ADDR_AN_CONTROL, 16'h004a);
         1: wr(ADDR_AN_CONTROL, 16'h0049);
         2: begin
            dropLag <= 4'($urandom);
            dropReq <= 1'b1;
            @(posedge sys_clk);
            dropReq <= 1'b0;
         end
         default: begin
            wr(ADDR_AN_CONTROL, 16'h004c);
            wr(ADDR_AN_CONTROL, 16'h0048);
         end
      endcase
      repeat (30) @(posedge sys_clk);
      rd(ADDR_ADVERT, live);
   endtask : stage_and_apply

   // Read data and received pages are matched against the oldest note
   always @(posedge sys_clk) begin
      if (rdPend) check(regRdData, rq.pop_front());
      if (codeValid) check(codeWord, wq.pop_front());
      rdPend <= regRd;
   end

   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      test_done();
   end

   initial begin
      {srst, regWr, regRd, strapAsym, strapSym, dropReq, rdPend} = 7'h40;
      {regAddr, regWrData, dropLag, live, d} = 57'h0;
      mismatches = 0;
      n_tests = 0;
      void'($urandom(32'h3af8));
      // Second pass is a hardware reset in mid-run after T4 may be set
      for (int r = 0; r < 2; r++) begin
         hw_reset();
         check(advertWord, live);
         rd(ADDR_ADVERT, live);
         wr(5'h1f, 16'hffff);
         rd(5'h1f, 16'h0);
         rd(ADDR_AN_STATUS, 16'h0009);
         rd(ADDR_AN_CONTROL, 16'h0048);
         for (int ev = 0; ev < 4; ev++) stage_and_apply(ev);
         for (int i = 0; i < 2; i++) begin
            wr(ADDR_AN_CONTROL, (i == 0) ? 16'h0030 : 16'h0010);
            repeat (3) @(posedge sys_clk);
            check({12'h0, anEnableEff, advGigFull, advGigHalf, autoNextPages},
                  (i == 0) ? 16'hd : 16'hb);
            check({14'h0, advertWord[8:7]}, 16'h0);
         end
         wr(ADDR_AN_CONTROL, 16'h0048);
      end
      repeat (10) @(posedge sys_clk);
      check(16'(rq.size() + wq.size()), 16'h0);
      test_done();
   end

endmodule : autoneg_advert_register_test

bind autoneg_advert_register autoneg_advert_props autoneg_advert_props_i (
   .sys_clk, .srst, .regAddr, .regWrData, .regWr, .regRd, .copperLinkUp,
   .regRdData, .advertWord, .advGigFull, .advGigHalf, .autoNextPages,
   .anRestart, .softResetOut);

`default_nettype wire
